// file: rtl/simio_pkg.sv
/*
 * Package for the simulation-mode I/O router: function codes, register
 * offsets, reset values and carrier structs.
 * Assumes a single clock domain and a plain strobed register port.
 */
package simio_pkg;

    // ***********************************************************
    // Function codes
    // ***********************************************************
    localparam logic [7:0] SIMIO_FN_NONE = 8'h00;
    localparam logic [7:0] SIMIO_FN_FREE = 8'h01;
    localparam logic [7:0] SIMIO_FN_ERR_CLR = 8'h0c;
    localparam logic [7:0] SIMIO_FN_GEN_IN_BASE = 8'h0e;
    localparam logic [7:0] SIMIO_FN_FWD_LIM = 8'h1c;
    localparam logic [7:0] SIMIO_FN_REV_LIM = 8'h1d;
    localparam logic [7:0] SIMIO_FN_HOME_SENS = 8'h1e;
    localparam logic [7:0] SIMIO_FN_EXTERNAL_IN_1 = 8'h68;
    localparam logic [7:0] SIMIO_FN_ALARM_B = 8'h82;
    localparam logic [7:0] SIMIO_FN_MOVING = 8'h86;
    localparam logic [7:0] SIMIO_FN_ERR_MON = 8'h89;
    localparam logic [7:0] SIMIO_FN_EXC_MON = 8'h8e;
    localparam logic [7:0] SIMIO_FN_HOME_END = 8'h90;
    localparam logic [7:0] SIMIO_FN_GEN_RESP_BASE = 8'ha0;
    localparam int SIMIO_NUM_GEN = 16;

    // ***********************************************************
    // Reset values of the direct pin functions
    // ***********************************************************
    localparam logic [47:0] SIMIO_DIN_FN_RST = {8'h1d, 8'h1c, 8'h68, 8'h0c, 8'h01, 8'h1e};
    localparam logic [47:0] SIMIO_DOUT_FN_RST = {8'h82, 8'h86, 8'h8e, 8'h00, 8'h89, 8'h90};
    localparam logic [5:0] SIMIO_INV_RST = 6'h00;

    // ***********************************************************
    // Register offsets (word index)
    // ***********************************************************
    localparam logic [5:0] SIMIO_A_CTRL = 6'h00;
    localparam logic [5:0] SIMIO_A_STATUS = 6'h01;
    localparam logic [5:0] SIMIO_A_IRQ_STAT = 6'h02;
    localparam logic [5:0] SIMIO_A_IRQ_EN = 6'h03;
    localparam logic [5:0] SIMIO_A_IRQ_CLR = 6'h04;
    localparam logic [5:0] SIMIO_A_INV = 6'h05;
    localparam logic [5:0] SIMIO_A_REMOTE_IN = 6'h06;
    localparam logic [5:0] SIMIO_A_REMOTE_OUT = 6'h07;
    localparam logic [5:0] SIMIO_A_DIN_FN = 6'h10;
    localparam logic [5:0] SIMIO_A_DOUT_FN = 6'h18;
    localparam logic [5:0] SIMIO_A_RIN_FN = 6'h20;
    localparam logic [5:0] SIMIO_A_ROUT_FN = 6'h30;

    // Control bits
    localparam int SIMIO_CTRL_SIM = 0;
    localparam int SIMIO_CTRL_HOMING = 1;
    localparam int SIMIO_CTRL_SRC_SEL = 2;

    // Interrupt bits
    localparam int SIMIO_IRQ_HOME_DONE = 0;
    localparam int SIMIO_IRQ_HOME_SENS = 1;
    localparam int SIMIO_IRQ_SENS_ERR = 2;
    localparam int SIMIO_IRQ_W = 3;

    // ***********************************************************
    // Types
    // ***********************************************************
    typedef enum logic [1:0] {
        SIMIO_H_IDLE = 2'b00,
        SIMIO_H_SEEK = 2'b01,
        SIMIO_H_DONE = 2'b10
    } simio_home_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } simio_bus_t;

    typedef struct packed {
        logic coords_set;
        logic mech_home_set;
        logic factory_home_set;
        logic sensor_err;
        logic motor_excited;
        logic brake_released;
    } simio_drv_t;

endpackage

// file: rtl/simio_router.sv
/*
 * Simulation-mode I/O router: direct pin inversion and function mapping,
 * general-purpose signal routing, simulated homing and forced status outputs.
 * Assumes all inputs are synchronous to mclk and the register master
 * follows the one-cycle strobe protocol.
 */
// The address map and the address-and-strobe port are this design's own decisions.
// What this block does
// - Command source follows fieldbus main device in cyclic and profile modes, also in simulation
// - Fieldbus homing start in simulation begins a simulated homing, motor stays still
// - Simulated homing completion never rewrites the encoder stored home
// - I/O parameter settings except remote output function codes ignored while simulation is active
// - In simulation motor stays unexcited and brake holds
// - Free-run in simulation drives excitation monitor and brake outputs low
// - Coordinates-valid output forced on in simulation, else follows coordinates set
// - Mechanical-home-set output forced off in simulation
// - Factory-home-set output forced off in simulation
// - Power-on sensor error alarm suppressed in simulation
// - Sixteen general inputs each with a response output
// - Remote input bit mapped to general input drives mapped direct output
// - Direct input mapped to general input reads back on mapped remote output bit
// - Each direct pin has an inversion bit, 0 pass, 1 invert, reset 0
// - Direct input function codes selectable with documented defaults
// - Direct output function codes selectable with documented defaults
// - Remote input function codes selectable, all default to no function
`timescale 1ns/10ps
`default_nettype none
module simio_router
    import simio_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire simio_bus_t bus,
    output logic [31:0] rdata,
    input wire logic [5:0] direct_in,
    output logic [5:0] direct_out,
    input wire simio_drv_t drv,
    input wire logic fieldbus_cmd_valid,
    input wire logic [31:0] fieldbus_cmd,
    input wire logic [31:0] local_cmd,
    input wire logic moving_in,
    input wire logic alarm_in,
    input wire logic error_in,
    output logic [31:0] cmd_data,
    output logic coords_valid_out,
    output logic mech_home_set_out,
    output logic factory_home_set_out,
    output logic excitation_monitor_out,
    output logic brake_control_out,
    output logic motor_excite,
    output logic brake_release,
    output logic encoder_home_write,
    output logic homing_done,
    output logic sensor_err_alarm,
    output logic irq
);

    // ***********************************************************
    // State
    // ***********************************************************
    typedef struct packed {
        logic [31:0] rdata;
        logic [2:0] ctrl;
        logic [5:0] din_inv;
        logic [5:0] dout_inv;
        logic [47:0] din_fn;
        logic [47:0] dout_fn;
        logic [127:0] rin_fn;
        logic [127:0] rout_fn;
        logic [15:0] remote_in;
        logic [15:0] remote_out;
        logic [5:0] direct_out;
        logic [31:0] cmd_data;
        simio_home_t home;
        logic homing_prev;
        logic home_sens_prev;
        logic coords_valid;
        logic mech_home;
        logic factory_home;
        logic exc_mon;
        logic brake_out;
        logic motor_excite;
        logic brake_release;
        logic enc_home_wr;
        logic homing_done;
        logic sens_err;
        logic [SIMIO_IRQ_W-1:0] irq_stat;
        logic [SIMIO_IRQ_W-1:0] irq_en;
        logic irq;
    } simio_state_t;

    simio_state_t st;
    simio_state_t next_st;

    // ***********************************************************
    // Decoding helpers
    // ***********************************************************
    // Select byte k of a packed code table
    function automatic logic [7:0] simio_code(input logic [127:0] tbl, input int k);
        simio_code = tbl[k*8 +: 8];
    endfunction

    // Register index within a table window, top end widened past the map
    function automatic logic simio_hit(input logic [5:0] a, input logic [5:0] base, input int n);
        logic [6:0] top;
        top = {1'b0, base} + 7'(n);
        simio_hit = (a >= base) && ({1'b0, a} < top);
    endfunction

    // General input code range
    function automatic logic simio_is_gen_in(input logic [7:0] c);
        simio_is_gen_in = (c >= SIMIO_FN_GEN_IN_BASE) && (c < SIMIO_FN_GEN_IN_BASE + 8'h10);
    endfunction

    // Response output code range
    function automatic logic simio_is_gen_resp(input logic [7:0] c);
        simio_is_gen_resp = (c >= SIMIO_FN_GEN_RESP_BASE) && (c < SIMIO_FN_GEN_RESP_BASE + 8'h10);
    endfunction

    logic sim;
    logic [5:0] din_log;
    logic [15:0] gen_in;
    logic free_in;
    logic home_sens;
    logic [5:0] din_inv_eff;
    logic [5:0] dout_inv_eff;
    logic [47:0] din_fn_eff;
    logic [47:0] dout_fn_eff;
    logic [127:0] rin_fn_eff;
    logic [127:0] rout_fn_eff;
    logic [5:0] dout_log;
    logic [SIMIO_IRQ_W-1:0] ev;
    logic [7:0] code;
    logic [3:0] idx;

    always_comb
    begin
        next_st = st;
        sim = st.ctrl[SIMIO_CTRL_SIM];
        code = 8'h00;
        idx = 4'h0;

        // ***********************************************************
        // Effective settings: defaults while simulating, except remote output codes
        // ***********************************************************
        din_inv_eff = sim ? SIMIO_INV_RST : st.din_inv;
        dout_inv_eff = sim ? SIMIO_INV_RST : st.dout_inv;
        din_fn_eff = sim ? SIMIO_DIN_FN_RST : st.din_fn;
        dout_fn_eff = sim ? SIMIO_DOUT_FN_RST : st.dout_fn;
        rin_fn_eff = sim ? '0 : st.rin_fn;
        rout_fn_eff = st.rout_fn;

        // ***********************************************************
        // Input side: invert then map
        // ***********************************************************
        din_log = direct_in ^ din_inv_eff;
        gen_in = 16'h0000;
        free_in = 1'b0;
        home_sens = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            code = din_fn_eff[i*8 +: 8];
            if (simio_is_gen_in(code))
            begin
                idx = 4'(code - SIMIO_FN_GEN_IN_BASE);
                gen_in[idx] = gen_in[idx] | din_log[i];
            end
            if (code == SIMIO_FN_FREE)
                free_in = free_in | din_log[i];
            if (code == SIMIO_FN_HOME_SENS)
                home_sens = home_sens | din_log[i];
        end
        for (int i = 0; i < 16; i++)
        begin
            code = simio_code(rin_fn_eff, i);
            if (simio_is_gen_in(code))
            begin
                idx = 4'(code - SIMIO_FN_GEN_IN_BASE);
                gen_in[idx] = gen_in[idx] | st.remote_in[i];
            end
            if (code == SIMIO_FN_FREE)
                free_in = free_in | st.remote_in[i];
            if (code == SIMIO_FN_HOME_SENS)
                home_sens = home_sens | st.remote_in[i];
        end

        // ***********************************************************
        // Drive state and forced status
        // ***********************************************************
        next_st.motor_excite = sim ? 1'b0 : (drv.motor_excited & ~free_in);
        next_st.brake_release = sim ? 1'b0 : (drv.brake_released & ~free_in);
        next_st.exc_mon = sim ? ~free_in & 1'b0 : (drv.motor_excited & ~free_in);
        next_st.brake_out = sim ? 1'b0 : (drv.brake_released & ~free_in);
        next_st.coords_valid = sim ? 1'b1 : drv.coords_set;
        next_st.mech_home = sim ? 1'b0 : drv.mech_home_set;
        next_st.factory_home = sim ? 1'b0 : drv.factory_home_set;
        next_st.sens_err = sim ? 1'b0 : drv.sensor_err;

        // Command source
        if (fieldbus_cmd_valid)
            next_st.cmd_data = fieldbus_cmd;
        else if (!st.ctrl[SIMIO_CTRL_SRC_SEL])
            next_st.cmd_data = local_cmd;

        // ***********************************************************
        // Simulated homing
        // ***********************************************************
        next_st.homing_prev = st.ctrl[SIMIO_CTRL_HOMING];
        next_st.home_sens_prev = home_sens;
        next_st.enc_home_wr = 1'b0;
        next_st.homing_done = 1'b0;
        unique case (st.home)
            SIMIO_H_IDLE:
                if (sim && st.ctrl[SIMIO_CTRL_HOMING] && !st.homing_prev)
                    next_st.home = SIMIO_H_SEEK;
            SIMIO_H_SEEK:
                if (home_sens)
                begin
                    next_st.home = SIMIO_H_DONE;
                    next_st.homing_done = 1'b1;
                end
                else if (!st.ctrl[SIMIO_CTRL_HOMING])
                    next_st.home = SIMIO_H_IDLE;
            SIMIO_H_DONE:
                if (!st.ctrl[SIMIO_CTRL_HOMING])
                    next_st.home = SIMIO_H_IDLE;
            default:
                next_st.home = SIMIO_H_IDLE;
        endcase
        // Encoder home only rewritten by a real homing
        if (!sim && st.ctrl[SIMIO_CTRL_HOMING] && home_sens && !st.home_sens_prev)
            next_st.enc_home_wr = 1'b1;

        // ***********************************************************
        // Output side: map then invert
        // ***********************************************************
        dout_log = 6'h00;
        for (int i = 0; i < 6; i++)
        begin
            code = dout_fn_eff[i*8 +: 8];
            if (simio_is_gen_resp(code))
                dout_log[i] = gen_in[4'(code - SIMIO_FN_GEN_RESP_BASE)];
            else if (code == SIMIO_FN_HOME_END)
                dout_log[i] = (st.home == SIMIO_H_DONE);
            else if (code == SIMIO_FN_ERR_MON)
                dout_log[i] = error_in;
            else if (code == SIMIO_FN_EXC_MON)
                dout_log[i] = next_st.exc_mon;
            else if (code == SIMIO_FN_MOVING)
                dout_log[i] = moving_in;
            else if (code == SIMIO_FN_ALARM_B)
                dout_log[i] = ~alarm_in;
        end
        next_st.direct_out = dout_log ^ dout_inv_eff;
        for (int i = 0; i < 16; i++)
        begin
            code = simio_code(rout_fn_eff, i);
            next_st.remote_out[i] = 1'b0;
            if (simio_is_gen_resp(code))
                next_st.remote_out[i] = gen_in[4'(code - SIMIO_FN_GEN_RESP_BASE)];
            else if (code == SIMIO_FN_HOME_END)
                next_st.remote_out[i] = (st.home == SIMIO_H_DONE);
        end

        // ***********************************************************
        // Interrupts: set wins over clear
        // ***********************************************************
        ev = '0;
        ev[SIMIO_IRQ_HOME_DONE] = next_st.homing_done;
        ev[SIMIO_IRQ_HOME_SENS] = home_sens & ~st.home_sens_prev;
        ev[SIMIO_IRQ_SENS_ERR] = next_st.sens_err;
        if (bus.wr && bus.addr == SIMIO_A_IRQ_CLR)
            next_st.irq_stat = st.irq_stat & ~bus.wdata[SIMIO_IRQ_W-1:0];
        next_st.irq_stat = next_st.irq_stat | ev;
        next_st.irq = |(next_st.irq_stat & st.irq_en);

        // ***********************************************************
        // Register writes
        // ***********************************************************
        if (bus.wr)
        begin
            if (bus.addr == SIMIO_A_CTRL)
                next_st.ctrl = bus.wdata[2:0];
            if (bus.addr == SIMIO_A_IRQ_EN)
            begin
                next_st.irq_en = bus.wdata[SIMIO_IRQ_W-1:0];
                next_st.irq = |(next_st.irq_stat & bus.wdata[SIMIO_IRQ_W-1:0]);
            end
            if (bus.addr == SIMIO_A_INV)
            begin
                next_st.din_inv = bus.wdata[5:0];
                next_st.dout_inv = bus.wdata[13:8];
            end
            if (bus.addr == SIMIO_A_REMOTE_IN)
                next_st.remote_in = bus.wdata[15:0];
            if (simio_hit(bus.addr, SIMIO_A_DIN_FN, 6))
                next_st.din_fn[(bus.addr - SIMIO_A_DIN_FN)*8 +: 8] = bus.wdata[7:0];
            if (simio_hit(bus.addr, SIMIO_A_DOUT_FN, 6))
                next_st.dout_fn[(bus.addr - SIMIO_A_DOUT_FN)*8 +: 8] = bus.wdata[7:0];
            if (simio_hit(bus.addr, SIMIO_A_RIN_FN, 16))
                next_st.rin_fn[(bus.addr - SIMIO_A_RIN_FN)*8 +: 8] = bus.wdata[7:0];
            if (simio_hit(bus.addr, SIMIO_A_ROUT_FN, 16))
                next_st.rout_fn[(bus.addr - SIMIO_A_ROUT_FN)*8 +: 8] = bus.wdata[7:0];
        end

        // ***********************************************************
        // Register reads, unmapped read as zero
        // ***********************************************************
        next_st.rdata = 32'h0000_0000;
        if (bus.rd)
        begin
            if (bus.addr == SIMIO_A_CTRL)
                next_st.rdata = {29'h0, st.ctrl};
            else if (bus.addr == SIMIO_A_STATUS)
                next_st.rdata = {24'h0, 1'b0, st.home, st.coords_valid, st.mech_home,
                                 st.factory_home, st.exc_mon, st.brake_out};
            else if (bus.addr == SIMIO_A_IRQ_STAT)
                next_st.rdata = {29'h0, st.irq_stat};
            else if (bus.addr == SIMIO_A_IRQ_EN)
                next_st.rdata = {29'h0, st.irq_en};
            else if (bus.addr == SIMIO_A_INV)
                next_st.rdata = {18'h0, st.dout_inv, 2'h0, st.din_inv};
            else if (bus.addr == SIMIO_A_REMOTE_IN)
                next_st.rdata = {16'h0, st.remote_in};
            else if (bus.addr == SIMIO_A_REMOTE_OUT)
                next_st.rdata = {16'h0, st.remote_out};
            else if (simio_hit(bus.addr, SIMIO_A_DIN_FN, 6))
                next_st.rdata = {24'h0, st.din_fn[(bus.addr - SIMIO_A_DIN_FN)*8 +: 8]};
            else if (simio_hit(bus.addr, SIMIO_A_DOUT_FN, 6))
                next_st.rdata = {24'h0, st.dout_fn[(bus.addr - SIMIO_A_DOUT_FN)*8 +: 8]};
            else if (simio_hit(bus.addr, SIMIO_A_RIN_FN, 16))
                next_st.rdata = {24'h0, st.rin_fn[(bus.addr - SIMIO_A_RIN_FN)*8 +: 8]};
            else if (simio_hit(bus.addr, SIMIO_A_ROUT_FN, 16))
                next_st.rdata = {24'h0, st.rout_fn[(bus.addr - SIMIO_A_ROUT_FN)*8 +: 8]};
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.din_fn <= SIMIO_DIN_FN_RST;
            st.dout_fn <= SIMIO_DOUT_FN_RST;
            st.din_inv <= SIMIO_INV_RST;
            st.dout_inv <= SIMIO_INV_RST;
            st.home <= SIMIO_H_IDLE;
        end
        else
            st <= next_st;
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    assign rdata = st.rdata;
    assign direct_out = st.direct_out;
    assign cmd_data = st.cmd_data;
    assign coords_valid_out = st.coords_valid;
    assign mech_home_set_out = st.mech_home;
    assign factory_home_set_out = st.factory_home;
    assign excitation_monitor_out = st.exc_mon;
    assign brake_control_out = st.brake_out;
    assign motor_excite = st.motor_excite;
    assign brake_release = st.brake_release;
    assign encoder_home_write = st.enc_home_wr;
    assign homing_done = st.homing_done;
    assign sensor_err_alarm = st.sens_err;
    assign irq = st.irq;

endmodule
`default_nettype wire

// file: tb/simio_properties.sv
/*
 Port checker of the simulation-mode I/O router.
 Assumes a bind onto simio_router and one mclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module simio_properties
    import simio_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire simio_bus_t bus,
    input wire logic [5:0] direct_in,
    input wire simio_drv_t drv,
    input wire logic fieldbus_cmd_valid,
    input wire logic [31:0] fieldbus_cmd,
    input wire logic [31:0] cmd_data,
    input wire logic coords_valid_out,
    input wire logic mech_home_set_out,
    input wire logic factory_home_set_out,
    input wire logic excitation_monitor_out,
    input wire logic brake_control_out,
    input wire logic motor_excite,
    input wire logic brake_release,
    input wire logic encoder_home_write,
    input wire logic homing_done,
    input wire logic sensor_err_alarm
);
    // ***********************************************************
    // Shadow of the simulation flag
    // ***********************************************************
    logic sim;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sim <= 1'b0;
        else if (bus.wr && bus.addr == SIMIO_A_CTRL)
            sim <= bus.wdata[SIMIO_CTRL_SIM];
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // ***********************************************************
    // Properties
    // ***********************************************************
    coords_forced_a: assert property ($past(sim) |-> coords_valid_out)
        else $error("coords valid not forced in sim");
    coords_follow_a: assert property ($past(rst_b) && !$past(sim) |-> coords_valid_out == $past(drv.coords_set))
        else $error("coords valid not following drive");
    mech_off_a: assert property ($past(sim) |-> !mech_home_set_out)
        else $error("mech home set on in sim");
    factory_off_a: assert property ($past(sim) |-> !factory_home_set_out)
        else $error("factory home set on in sim");
    sens_err_quiet_a: assert property ($rose(sensor_err_alarm) |-> !$past(sim))
        else $error("sensor error raised in sim");
    motor_still_a: assert property ($past(sim) |-> !motor_excite && !brake_release)
        else $error("motor excited or brake released in sim");
    free_run_low_a: assert property ($past(sim) && $past(direct_in[1]) |-> !excitation_monitor_out && !brake_control_out)
        else $error("monitors high under free run");
    enc_home_kept_a: assert property ($past(sim) |-> !encoder_home_write)
        else $error("encoder home written in sim");
    cmd_source_a: assert property (fieldbus_cmd_valid |=> cmd_data == $past(fieldbus_cmd))
        else $error("command not taken from fieldbus");
    home_pulse_a: assert property (homing_done |=> !homing_done)
        else $error("homing done longer than one cycle");
    cover property ($past(sim) && coords_valid_out);
    cover property (homing_done);
    cover property (fieldbus_cmd_valid);
endmodule
`default_nettype wire

// file: tb/simio_field_dev.sv
/*
 Field device model on the direct input pins.
 Assumes the bench sets the levels after a rising mclk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module simio_field_dev
(
    input wire logic [5:0] level,
    input wire logic home_req,
    output logic [5:0] direct_in
);
    // Home sensor asserted on request
    assign direct_in = {level[5:1], level[0] | home_req};
endmodule
`default_nettype wire

// file: tb/tb_simio_router.sv
/*
 Self-checking bench of the simulation-mode I/O router.
 Assumes simio_router, simio_field_dev and simio_properties compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_simio_router
    import simio_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    simio_bus_t bus = '0;
    simio_drv_t drv = '0;
    logic [31:0] rdata, cmd_data, d;
    logic [31:0] fieldbus_cmd = 32'h0, local_cmd = 32'h0;
    logic [5:0] direct_in, direct_out;
    logic [5:0] level = 6'h00;
    logic fieldbus_cmd_valid = 1'b0, home_req = 1'b0;
    logic moving_in = 1'b0, alarm_in = 1'b0, error_in = 1'b0;
    logic coords_valid_out, mech_home_set_out, factory_home_set_out;
    logic excitation_monitor_out, brake_control_out, motor_excite, brake_release;
    logic encoder_home_write, homing_done, sensor_err_alarm, irq;
    int num_errors = 0, checks_done = 0, cyc = 0, enc_seen = 0, i, v;
    int din_def[6] = '{30, 1, 12, 104, 28, 29};
    int dout_def[6] = '{144, 137, 0, 142, 134, 130};
    simio_router i_simio_router (.*);
    simio_field_dev i_simio_field_dev (.*);
    always #25 mclk = ~mclk;
    // ***********************************************************
    // Bus tasks and helpers
    // ***********************************************************
    task automatic wr(input logic [5:0] a, input logic [31:0] x);
        @(posedge mclk);
        bus <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] x);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1 x = rdata;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] x;
        rd(a, x);
        `CHK(x, e)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (encoder_home_write === 1'b1)
            enc_seen++;
        if (cyc == 4000)
        begin
            num_errors++;
            summarize();
        end
    end
    // ***********************************************************
    // Tests
    // ***********************************************************
    initial
    begin
        local_cmd <= $urandom(94620);
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            rdc(6'(SIMIO_A_DIN_FN + i), 32'(din_def[i]));
            rdc(6'(SIMIO_A_DOUT_FN + i), 32'(dout_def[i]));
        end
        for (i = 0; i < 16; i++)
            rdc(6'(SIMIO_A_RIN_FN + i), 32'h0);
        rdc(SIMIO_A_INV, 32'h0);
        rdc(6'h08, 32'h0);
        $display("test 1 finished");
        wr(SIMIO_A_RIN_FN, 32'h0e);
        wr(6'(SIMIO_A_DOUT_FN + 2), 32'ha0);
        rdc(6'(SIMIO_A_DOUT_FN + 2), 32'ha0);
        for (i = 0; i < 8; i++)
        begin
            v = $urandom % 2;
            if (i == 4)
                wr(SIMIO_A_INV, 32'h400);
            wr(SIMIO_A_REMOTE_IN, 32'(v));
            settle(3);
            `CHK(direct_out[2], 1'(v) ^ (i >= 4))
        end
        $display("test 2 finished");
        wr(6'(SIMIO_A_DIN_FN + 1), 32'h0f);
        wr(6'(SIMIO_A_ROUT_FN + 1), 32'ha1);
        for (i = 0; i < 8; i++)
        begin
            v = $urandom % 64;
            if (i == 4)
                wr(SIMIO_A_INV, 32'h2);
            @(posedge mclk);
            level <= 6'(v);
            settle(3);
            rd(SIMIO_A_REMOTE_OUT, d);
            `CHK(d[1], 1'(v >> 1) ^ (i >= 4))
        end
        $display("test 3 finished");
        `CHK({coords_valid_out, mech_home_set_out, factory_home_set_out}, 3'b000)
        @(posedge mclk);
        drv <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        wr(SIMIO_A_REMOTE_IN, 32'h1);
        settle(3);
        `CHK({coords_valid_out, mech_home_set_out, factory_home_set_out, sensor_err_alarm}, 4'b1111)
        `CHK(direct_out[2], 1'b1)
        wr(SIMIO_A_CTRL, 32'h1);
        @(posedge mclk);
        drv.sensor_err <= 1'b1;
        level <= 6'h02;
        settle(3);
        `CHK({coords_valid_out, mech_home_set_out, factory_home_set_out}, 3'b100)
        `CHK({sensor_err_alarm, motor_excite, brake_release}, 3'b000)
        `CHK({excitation_monitor_out, brake_control_out}, 2'b00)
        `CHK(direct_out[2], 1'b0)
        $display("test 4 finished");
        wr(SIMIO_A_IRQ_CLR, 32'h7);
        wr(SIMIO_A_IRQ_EN, 32'h1);
        wr(SIMIO_A_CTRL, 32'h3);
        settle(4);
        `CHK(homing_done, 1'b0)
        @(posedge mclk);
        home_req <= 1'b1;
        for (i = 0; i < 20 && homing_done !== 1'b1; i++)
            settle(1);
        `CHK(homing_done, 1'b1)
        `CHK(motor_excite, 1'b0)
        settle(2);
        `CHK(irq, 1'b1)
        `CHK(enc_seen, 0)
        rd(SIMIO_A_IRQ_STAT, d);
        `CHK(d[0], 1'b1)
        wr(SIMIO_A_IRQ_CLR, 32'h1);
        settle(2);
        `CHK(irq, 1'b0)
        $display("test 5 finished");
        `CHK(cmd_data, local_cmd)
        for (i = 0; i < 4; i++)
        begin
            v = $urandom;
            @(posedge mclk);
            fieldbus_cmd <= 32'(v);
            fieldbus_cmd_valid <= 1'b1;
            settle(2);
            `CHK(cmd_data, 32'(v))
        end
        wr(SIMIO_A_CTRL, 32'h4);
        fieldbus_cmd_valid <= 1'b0;
        local_cmd <= ~local_cmd;
        settle(2);
        `CHK(cmd_data, 32'(v))
        $display("test 6 finished");
        summarize();
    end
endmodule
bind simio_router simio_properties i_simio_properties (.*);
`default_nettype wire
